// File: tb/tfp_ext_src.sv
// Purpose: external clock source on the count pin
// Assumes: half period well above one system clock
// Notes: pin rests low between bursts
module tfp_ext_src
(
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b0;
   task burst(input int n);
      repeat (n)
      begin
         #250 pin = 1'b1;
         #250 pin = 1'b0;
      end
   endtask : burst
endmodule : tfp_ext_src

// File: tb/tfp_timer_chk.sv
// Purpose: port assertions for the timer block
// Assumes: bound into tfp_timer
// Notes: irq levels lag their flags one cycle
module tfp_timer_chk
   import tfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tfp_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic global_irq_enable,
   input wire logic compare_vector_ack,
   input wire logic compare_irq,
   input wire logic overflow_irq,
   input wire logic compare_match,
   input wire logic [3:0] prescale_taps
);
   default clocking
      @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_CMP_GATE: assert property (
      compare_irq |-> $past(global_irq_enable))
      else $error("compare irq without global enable");
   AST_OVF_GATE: assert property (
      overflow_irq |-> $past(global_irq_enable))
      else $error("overflow irq without global enable");
   AST_RD_IDLE: assert property (
      !$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   AST_SFC_ZERO: assert property (
      bus_req.rd && bus_req.addr == 3'h4 |=> rdata == 8'h00)
      else $error("prescaler reset bit read nonzero");
   AST_TAP_GAP: assert property (
      prescale_taps[0] |=> !prescale_taps[0] [*7])
      else $error("divide by 8 tap too close");
   AST_TAP_NEST: assert property (
      prescale_taps[3] |-> &prescale_taps)
      else $error("taps not from one counter");
   AST_CMP_ACK: assert property (
      compare_vector_ack ##1 !compare_match |=> !compare_irq)
      else $error("compare irq after vector ack");
   AST_CMP_ONE: assert property (
      compare_match |=> !compare_match)
      else $error("compare match longer than one cycle");
endmodule : tfp_timer_chk

bind tfp_timer tfp_timer_chk tfp_timer_chk_inst (.clk, .rst_n, .bus_req,
   .rdata, .global_irq_enable, .compare_vector_ack, .compare_irq,
   .overflow_irq, .compare_match, .prescale_taps);

// File: tb/tfp_timer_tb.sv
// Purpose: self-checking bench of the timer block
// Assumes: 10 MHz clock, reset held 16 cycles
// Notes: reads checked from a queue of expected ranges
`include "tfp_defines.svh"
`define CHK(nm, ex, got) \
begin \
   n_checks++; \
   if ((got) !== (ex)) \
   begin \
      err_count++; \
      $display("mismatch %s exp %h got %h", nm, ex, got); \
   end \
end
module tfp_timer_tb
   import tfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, gie, cack, oack, cirq, oirq, cm, pin;
   logic rd_seen = 1'b0;
   logic [7:0] rdata, v;
   logic [3:0] taps;
   logic [15:0] e;
   tfp_bus_req_t req;
   int err_count, n_checks, k;
   logic [15:0] expq[$];
   logic [31:0] lfsr = 32'h296913A6;
   int dv[4] = '{8, 64, 256, 1024};

   tfp_timer tfp_timer_inst (.clk, .rst_n, .bus_req(req), .rdata,
      .count_pin_a(pin), .global_irq_enable(gie), .compare_vector_ack(cack),
      .overflow_vector_ack(oack), .compare_irq(cirq), .overflow_irq(oirq),
      .compare_match(cm), .prescale_taps(taps));
   tfp_ext_src tfp_ext_src_inst (.pin);

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task op(input logic w, input logic r, input logic [2:0] a,
      input logic [7:0] d);
      @(posedge clk);
      req <= '{a, d, w, r};
   endtask : op
   task idle(input int n);
      repeat (n) op(1'b0, 1'b0, 3'h0, 8'h00);
   endtask : idle
   task rd(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
      expq.push_back({lo, hi});
      op(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   task run(input logic [7:0] s, input logic [7:0] cs, input int m);
      op(1'b1, 1'b0, `TFP_ADDR_COUNTER, s);
      op(1'b1, 1'b0, `TFP_ADDR_CONTROL, cs);
      idle(m);
      op(1'b1, 1'b0, `TFP_ADDR_CONTROL, 8'h00);
      idle(1);
   endtask : run
   task chk_irq(input logic ec, input logic eo);
      idle(2);
      @(negedge clk);
      `CHK("compare_irq", ec, cirq)
      `CHK("overflow_irq", eo, oirq)
   endtask : chk_irq
   task close_out;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // read data stands only in the cycle after the strobe
   always @(posedge clk) rd_seen <= req.rd;
   always @(negedge clk)
      if (rd_seen)
      begin
         e = expq.pop_front();
         `CHK("rdata", (rdata inside {[e[15:8]:e[7:0]]}) === 1'b1 ? rdata : e[15:8], rdata)
      end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out;
   end

   initial
   begin
      {rst_n, gie, cack, oack} = 4'h0;
      req = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < 8; k++) rd(k[2:0], 8'h00, 8'h00);
      repeat (4)
      begin
         lfsr = lfsr_next(lfsr);
         v = lfsr[7:0];
         op(1'b1, 1'b0, `TFP_ADDR_COMPARE, v);
         rd(`TFP_ADDR_COMPARE, v, v);
         op(1'b1, 1'b0, `TFP_ADDR_COUNTER, ~v);
         rd(`TFP_ADDR_COUNTER, ~v, ~v);
      end
      op(1'b1, 1'b0, `TFP_ADDR_SFC, 8'h01);
      rd(`TFP_ADDR_SFC, 8'h00, 8'h00);
      op(1'b1, 1'b0, `TFP_ADDR_COMPARE, 8'h20);
      op(1'b1, 1'b0, `TFP_ADDR_MASK, 8'h03);
      run(8'h20, 8'h01, 3);
      rd(`TFP_ADDR_FLAGS, 8'h00, 8'h00);
      run(8'h1E, 8'h01, 3);
      rd(`TFP_ADDR_FLAGS, 8'h02, 8'h02);
      rd(`TFP_ADDR_COUNTER, 8'h22, 8'h22);
      chk_irq(1'b0, 1'b0);
      @(posedge clk);
      gie <= 1'b1;
      chk_irq(1'b1, 1'b0);
      op(1'b1, 1'b0, `TFP_ADDR_FLAGS, 8'h00);
      chk_irq(1'b1, 1'b0);
      op(1'b1, 1'b0, `TFP_ADDR_FLAGS, 8'h02);
      chk_irq(1'b0, 1'b0);
      run(8'hFE, 8'h01, 3);
      chk_irq(1'b0, 1'b1);
      op(1'b1, 1'b0, `TFP_ADDR_MASK, 8'h02);
      chk_irq(1'b0, 1'b0);
      op(1'b1, 1'b0, `TFP_ADDR_MASK, 8'h03);
      run(8'h1E, 8'h01, 3);
      chk_irq(1'b1, 1'b1);
      @(posedge clk);
      {cack, oack} <= 2'h3;
      @(posedge clk);
      {cack, oack} <= 2'h0;
      chk_irq(1'b0, 1'b0);
      // phase-correct: up to ff, down to 00, turn back up
      run(8'hFF, 8'h09, 256);
      rd(`TFP_ADDR_COUNTER, 8'h02, 8'h02);
      rd(`TFP_ADDR_FLAGS, 8'h03, 8'h03);
      chk_irq(1'b1, 1'b1);
      op(1'b1, 1'b0, `TFP_ADDR_FLAGS, 8'h03);
      for (k = 6; k < 8; k++)
      begin
         op(1'b1, 1'b0, `TFP_ADDR_COUNTER, 8'h00);
         op(1'b1, 1'b0, `TFP_ADDR_CONTROL, k[7:0]);
         idle(2);
         tfp_ext_src_inst.burst(3);
         idle(5);
         op(1'b1, 1'b0, `TFP_ADDR_CONTROL, 8'h00);
         rd(`TFP_ADDR_COUNTER, 8'h03, 8'h03);
      end
      for (k = 2; k < 6; k++)
      begin
         run(8'h00, k[7:0], 4 * dv[k-2] - 1);
         rd(`TFP_ADDR_COUNTER, 8'h03, 8'h05);
      end
      idle(3);
      close_out;
   end
endmodule : tfp_timer_tb

// File: verilog/tfp_defines.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: offsets are local to this block
`ifndef TFP_DEFINES_SVH
`define TFP_DEFINES_SVH

`define TFP_ADDR_COUNTER 3'h0
`define TFP_ADDR_COMPARE 3'h1
`define TFP_ADDR_MASK 3'h2
`define TFP_ADDR_FLAGS 3'h3
`define TFP_ADDR_SFC 3'h4
`define TFP_ADDR_CONTROL 3'h5

`define TFP_BIT_CMP 1
`define TFP_BIT_OVF 0
`define TFP_BIT_PSR 0

`define TFP_RST_BYTE 8'h00
`define TFP_RST_CS 3'h0
`define TFP_RST_WGM 2'h0

`define TFP_PRE_W 10
`define TFP_DIV8_MASK 10'h007
`define TFP_DIV64_MASK 10'h03F
`define TFP_DIV256_MASK 10'h0FF
`define TFP_DIV1024_MASK 10'h3FF

`endif

// File: verilog/tfp_pkg.sv
// Purpose: shared types of the timer and prescaler block
// Assumes: nothing beyond the defines header
// Notes: clock select codes and bus carrier
package tfp_pkg;

   typedef enum logic [2:0] {
      TFP_CS_STOP = 3'h0,
      TFP_CS_DIRECT = 3'h1,
      TFP_CS_DIV8 = 3'h2,
      TFP_CS_DIV64 = 3'h3,
      TFP_CS_DIV256 = 3'h4,
      TFP_CS_DIV1024 = 3'h5,
      TFP_CS_EXT_FALL = 3'h6,
      TFP_CS_EXT_RISE = 3'h7
   } tfp_cs_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tfp_bus_req_t;

endpackage : tfp_pkg

// File: verilog/tfp_timer.sv
// Purpose: 8-bit timer counter with compare, flags and shared prescaler
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: wgm field only selects phase-correct up/down counting
`include "tfp_defines.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// - counter read/write; write blocks next match
// - 8-bit compare checked on every timer tick
// - compare irq needs mask bit1, global, flag
// - overflow irq needs mask bit0, global, flag
// - compare match sets flag bit1
// - vector acknowledge clears matching flag
// - writing one clears flag, zero keeps
// - overflow flag bit0; phase-correct at zero
// - select 1 counts every clock
// - prescaler taps 8, 64, 256, 1024
// - prescaler free running, shared by timers
// - first prescaled count 1..N cycles after the select write
// - count pin sampled through synchronizer
// - one tick per selected pin edge
// - counter updates 3-4 cycles after edge
// - external edges bypass the prescaler
// - prescaler reset bit self clears, reads zero
// - select codes: stop, direct, taps, edges
module tfp_timer
   import tfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tfp_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic count_pin_a,
   input wire logic global_irq_enable,
   input wire logic compare_vector_ack,
   input wire logic overflow_vector_ack,
   output logic compare_irq,
   output logic overflow_irq,
   output logic compare_match,
   output logic [3:0] prescale_taps
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] counter_value_q;
   logic [7:0] compare_value_q;
   logic [7:0] timer_irq_mask_q;
   logic compare_match_flag_q;
   logic overflow_flag_q;
   logic [2:0] clock_select_q;
   logic [1:0] wgm_q;
   logic down_q;
   logic [`TFP_PRE_W-1:0] presc_q;
   logic [2:0] pin_sync_q;
   logic pin_level_q;
   logic block_match_q;
   logic timer_tick;
   logic [3:0] tap;
   logic pin_rise;
   logic pin_fall;
   logic match_now;
   logic ovf_now;
   logic wr_counter;
   logic wr_flags;
   logic wr_sfc;
   logic psr_hit;

   assign wr_counter = bus_req.wr && bus_req.addr == `TFP_ADDR_COUNTER;
   assign wr_flags = bus_req.wr && bus_req.addr == `TFP_ADDR_FLAGS;
   assign wr_sfc = bus_req.wr && bus_req.addr == `TFP_ADDR_SFC;
   // hardware clears the request in the same cycle
   assign psr_hit = wr_sfc && bus_req.wdata[`TFP_BIT_PSR];

   ////////////////////////////////////////////////////////////////////////
   // shared prescaler
   always_ff @(posedge clk)
   begin
      if (!rst_n || psr_hit)
         presc_q <= '0;
      else
         presc_q <= presc_q + 1'b1;
   end

   // tap pulses at terminal count of each divisor
   assign tap[0] = (presc_q & `TFP_DIV8_MASK) == `TFP_DIV8_MASK;
   assign tap[1] = (presc_q & `TFP_DIV64_MASK) == `TFP_DIV64_MASK;
   assign tap[2] = (presc_q & `TFP_DIV256_MASK) == `TFP_DIV256_MASK;
   assign tap[3] = presc_q == `TFP_DIV1024_MASK;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prescale_taps <= 4'h0;
      else
         prescale_taps <= tap;
   end

   ////////////////////////////////////////////////////////////////////////
   // count pin synchronizer and edge detector
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_sync_q <= 3'h0;
         pin_level_q <= 1'b0;
      end
      else
      begin
         pin_sync_q <= {pin_sync_q[1:0], count_pin_a};
         if (pin_sync_q[1] == pin_sync_q[2])
            pin_level_q <= pin_sync_q[2];
      end
   end

   // edge seen once stages two and three agree on the new level
   assign pin_rise = pin_sync_q[1] && pin_sync_q[2] && !pin_level_q;
   assign pin_fall = !pin_sync_q[1] && !pin_sync_q[2] && pin_level_q;

   ////////////////////////////////////////////////////////////////////////
   // clock select
   always_comb
   begin
      case (tfp_cs_t'(clock_select_q))
         TFP_CS_STOP: timer_tick = 1'b0;
         TFP_CS_DIRECT: timer_tick = 1'b1;
         TFP_CS_DIV8: timer_tick = tap[0];
         TFP_CS_DIV64: timer_tick = tap[1];
         TFP_CS_DIV256: timer_tick = tap[2];
         TFP_CS_DIV1024: timer_tick = tap[3];
         TFP_CS_EXT_FALL: timer_tick = pin_fall;
         TFP_CS_EXT_RISE: timer_tick = pin_rise;
         default: timer_tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // counter
   assign match_now = counter_value_q == compare_value_q;
   assign ovf_now = timer_tick && (wgm_q == 2'h1 ?
      (down_q && counter_value_q == 8'h01) :
      counter_value_q == 8'hFF);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         counter_value_q <= `TFP_RST_BYTE;
         down_q <= 1'b0;
      end
      else if (wr_counter)
         counter_value_q <= bus_req.wdata;
      else if (timer_tick)
      begin
         if (wgm_q == 2'h1)
         begin
            if (!down_q && counter_value_q == 8'hFF)
            begin
               down_q <= 1'b1;
               counter_value_q <= 8'hFE;
            end
            else if (down_q && counter_value_q == 8'h00)
            begin
               down_q <= 1'b0;
               counter_value_q <= 8'h01;
            end
            else if (down_q)
               counter_value_q <= counter_value_q - 1'b1;
            else
               counter_value_q <= counter_value_q + 1'b1;
         end
         else
            counter_value_q <= counter_value_q + 1'b1;
      end
   end

   // a counter write masks the match of the next timer tick
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         block_match_q <= 1'b0;
      else if (wr_counter)
         block_match_q <= 1'b1;
      else if (timer_tick)
         block_match_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         compare_value_q <= `TFP_RST_BYTE;
         timer_irq_mask_q <= `TFP_RST_BYTE;
         clock_select_q <= `TFP_RST_CS;
         wgm_q <= `TFP_RST_WGM;
      end
      else if (bus_req.wr)
      begin
         case (bus_req.addr)
            `TFP_ADDR_COMPARE: compare_value_q <= bus_req.wdata;
            `TFP_ADDR_MASK: timer_irq_mask_q <= bus_req.wdata;
            `TFP_ADDR_CONTROL:
            begin
               clock_select_q <= bus_req.wdata[2:0];
               wgm_q <= bus_req.wdata[4:3];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: hardware set wins over any clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         compare_match_flag_q <= 1'b0;
      else if (timer_tick && match_now && !block_match_q)
         compare_match_flag_q <= 1'b1;
      else if (compare_vector_ack)
         compare_match_flag_q <= 1'b0;
      else if (wr_flags && bus_req.wdata[`TFP_BIT_CMP])
         compare_match_flag_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         overflow_flag_q <= 1'b0;
      else if (ovf_now)
         overflow_flag_q <= 1'b1;
      else if (overflow_vector_ack)
         overflow_flag_q <= 1'b0;
      else if (wr_flags && bus_req.wdata[`TFP_BIT_OVF])
         overflow_flag_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         compare_match <= 1'b0;
      else
         compare_match <= timer_tick && match_now && !block_match_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt requests
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         compare_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end
      else
      begin
         compare_irq <= timer_irq_mask_q[`TFP_BIT_CMP] && global_irq_enable
            && compare_match_flag_q;
         overflow_irq <= timer_irq_mask_q[`TFP_BIT_OVF] && global_irq_enable
            && overflow_flag_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (bus_req.rd)
      begin
         case (bus_req.addr)
            `TFP_ADDR_COUNTER: rdata <= counter_value_q;
            `TFP_ADDR_COMPARE: rdata <= compare_value_q;
            `TFP_ADDR_MASK: rdata <= timer_irq_mask_q;
            `TFP_ADDR_FLAGS:
               rdata <= {6'h00, compare_match_flag_q, overflow_flag_q};
            `TFP_ADDR_SFC: rdata <= 8'h00;
            `TFP_ADDR_CONTROL: rdata <= {3'h0, wgm_q, clock_select_q};
            default: rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

endmodule : tfp_timer
